// ===== bnv_pkg.sv
// Constants shared by the bytewide nonvolatile memory host controller.
package bnv_pkg;

  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 8;

  localparam int CLK_NS       = 40;
  localparam int ACCESS_NS    = 70;
  localparam int PRECHARGE_NS = 60;
  localparam int CE_MAX_NS    = 10000;

  // Least times round up, the longest time rounds down.
  localparam int ACCESS_CYC_I = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRECH_CYC_I  = (PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CE_MAX_CYC_I = CE_MAX_NS / CLK_NS;
  localparam int CE_LOW_CYC_I = (ACCESS_CYC_I < CE_MAX_CYC_I) ? ACCESS_CYC_I : CE_MAX_CYC_I;

  localparam logic [CNT_W-1:0] CE_LOW_CYC = CNT_W'(CE_LOW_CYC_I);
  localparam logic [CNT_W-1:0] PRECH_CYC  = CNT_W'(PRECH_CYC_I);
  localparam logic [CNT_W-1:0] SETUP_CYC  = 8'h01;

  localparam int BLOCK_LSB = 10;
  localparam int BLOCK_W   = 5;
  localparam int COL_LSB   = 8;
  localparam int COL_W     = 2;
  localparam int ROW_LSB   = 0;
  localparam int ROW_W     = 8;

  typedef enum logic [3:0] {
    BNV_IDLE   = 4'b0001,
    BNV_SETUP  = 4'b0010,
    BNV_ACCESS = 4'b0100,
    BNV_PRECH  = 4'b1000
  } bnv_state_t;

endpackage : bnv_pkg

// ===== bnv_timer.sv
// Down counter that times each phase of a memory cycle.
`timescale 1ns/1ns
module bnv_timer (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     load,
  input  wire logic [bnv_pkg::CNT_W-1:0] cycles,
  output logic                          expired
);

  logic [bnv_pkg::CNT_W-1:0] count;
  logic [bnv_pkg::CNT_W-1:0] next_count;

  assign expired    = (count == 8'h00);
  assign next_count = load ? (cycles - 8'h01) : (expired ? count : (count - 8'h01));

  // Phase length counter.
  // cycle counting
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count <= 8'h00;
    end
    else
    begin
      count <= next_count;
    end
  end

endmodule : bnv_timer

// ===== bnv_host.sv
// Host controller that runs read and write cycles on the bytewide memory pins.
`timescale 1ns/1ns
module bnv_host (
  input  wire logic                      core_clk,
  input  wire logic                      rst_b,
  input  wire logic                      reqValid,
  input  wire logic                      reqWrite,
  input  wire logic [bnv_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [bnv_pkg::DATA_W-1:0] reqWdata,
  output logic                           reqReady,
  output logic                           rspValid,
  output logic [bnv_pkg::DATA_W-1:0]      rspRdata,
  output logic [bnv_pkg::BLOCK_W-1:0]     blockSel,
  output logic [bnv_pkg::ROW_W-1:0]       rowSel,
  output logic [bnv_pkg::COL_W-1:0]       colSel,
  output logic                           rowRepeat,
  output logic                           memCe_b,
  output logic                           memOe_b,
  output logic                           memWe_b,
  output logic [bnv_pkg::ADDR_W-1:0]      memAddr,
  output logic [bnv_pkg::DATA_W-1:0]      memDqOut,
  output logic                           memDqOe,
  input  wire logic [bnv_pkg::DATA_W-1:0] memDqIn
);

  // Block and row of an address together name one physical row.
  function automatic logic [bnv_pkg::BLOCK_W+bnv_pkg::ROW_W-1:0] row_key(
    input logic [bnv_pkg::ADDR_W-1:0] a
  );
    row_key = {a[bnv_pkg::BLOCK_LSB +: bnv_pkg::BLOCK_W], a[bnv_pkg::ROW_LSB +: bnv_pkg::ROW_W]};
  endfunction : row_key

  bnv_pkg::bnv_state_t state;
  bnv_pkg::bnv_state_t next_state;

  logic                                     isWrite;
  logic                                     keyValid;
  logic [bnv_pkg::BLOCK_W+bnv_pkg::ROW_W-1:0] lastKey;
  logic                                     timerLoad;
  logic [bnv_pkg::CNT_W-1:0]                timerCycles;
  logic                                     phaseDone;

  wire accept    = (state == bnv_pkg::BNV_IDLE) && reqValid && reqReady;
  wire setupEnd  = (state == bnv_pkg::BNV_SETUP) && phaseDone;
  wire accessEnd = (state == bnv_pkg::BNV_ACCESS) && phaseDone;
  wire prechEnd  = (state == bnv_pkg::BNV_PRECH) && phaseDone;
  wire sameRow   = keyValid && (row_key(reqAddr) == lastKey);

  assign timerLoad   = accept || setupEnd || accessEnd;
  assign timerCycles = accept ? bnv_pkg::SETUP_CYC :
                       (setupEnd ? bnv_pkg::CE_LOW_CYC : bnv_pkg::PRECH_CYC);

  bnv_timer u_timer (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .load     (timerLoad),
    .cycles   (timerCycles),
    .expired  (phaseDone)
  );

  // Phase sequencing of one memory cycle.
  // access then precharge
  always_comb
  begin
    next_state = state;
    case (state)
      bnv_pkg::BNV_IDLE:
        if (accept)
        begin
          next_state = bnv_pkg::BNV_SETUP;
        end
      bnv_pkg::BNV_SETUP:
        if (setupEnd)
        begin
          next_state = bnv_pkg::BNV_ACCESS;
        end
      bnv_pkg::BNV_ACCESS:
        if (accessEnd)
        begin
          next_state = bnv_pkg::BNV_PRECH;
        end
      bnv_pkg::BNV_PRECH:
        if (prechEnd)
        begin
          next_state = bnv_pkg::BNV_IDLE;
        end
      default:
        next_state = bnv_pkg::BNV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= bnv_pkg::BNV_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Request handshake; a write needs no completion wait.
  // no busy polling
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reqReady <= 1'b0;
    end
    else
    begin
      reqReady <= (next_state == bnv_pkg::BNV_IDLE) && !accept;
    end
  end

  // Address and data are set up one phase before select falls.
  // address valid first
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memAddr  <= '0;
      memDqOut <= '0;
      isWrite  <= 1'b0;
    end
    else if (accept)
    begin
      memAddr  <= reqAddr;
      memDqOut <= reqWdata;
      isWrite  <= reqWrite;
    end
  end

  // Select pulses low once per address and rises to start precharge.
  // one pulse per address
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memCe_b <= 1'b1;
    end
    else if (setupEnd)
    begin
      memCe_b <= 1'b0;
    end
    else if (accessEnd)
    begin
      memCe_b <= 1'b1;
    end
  end

  // Write enable falls before select, giving a select controlled write.
  // address latched on fall
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memWe_b <= 1'b1;
      memOe_b <= 1'b1;
    end
    else if (accept)
    begin
      memWe_b <= !reqWrite;
      memOe_b <= 1'b1;
    end
    else if (setupEnd)
    begin
      memOe_b <= isWrite;
    end
    else if (accessEnd)
    begin
      memWe_b <= 1'b1;
      memOe_b <= 1'b1;
    end
  end

  // Write data stay driven through the select rise for data hold.
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      memDqOe <= 1'b0;
    end
    else if (accept)
    begin
      memDqOe <= reqWrite;
    end
    else if (prechEnd)
    begin
      memDqOe <= 1'b0;
    end
  end

  // Read data are sampled at the end of the select low phase.
  // access time met
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rspValid <= 1'b0;
      rspRdata <= '0;
    end
    else
    begin
      rspValid <= accessEnd;
      if (accessEnd && !isWrite)
      begin
        rspRdata <= memDqIn;
      end
    end
  end

  // Block, column and row of the access, and a flag for repeated row wear.
  // row and column decode
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blockSel  <= '0;
      rowSel    <= '0;
      colSel    <= '0;
      rowRepeat <= 1'b0;
      keyValid  <= 1'b0;
      lastKey   <= '0;
    end
    else if (accept)
    begin
      blockSel  <= reqAddr[bnv_pkg::BLOCK_LSB +: bnv_pkg::BLOCK_W];
      rowSel    <= reqAddr[bnv_pkg::ROW_LSB +: bnv_pkg::ROW_W];
      colSel    <= reqAddr[bnv_pkg::COL_LSB +: bnv_pkg::COL_W];
      rowRepeat <= sameRow;
      keyValid  <= 1'b1;
      lastKey   <= row_key(reqAddr);
    end
  end

endmodule : bnv_host

// ===== bnv_monitor.sv
// Assertions on select timing and address decode of the host controller.
`timescale 1ns/1ns
module bnv_monitor (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        reqValid,
  input wire logic        reqReady,
  input wire logic [14:0] reqAddr,
  input wire logic        rspValid,
  input wire logic [4:0]  blockSel,
  input wire logic [7:0]  rowSel,
  input wire logic [1:0]  colSel,
  input wire logic        memCe_b,
  input wire logic [14:0] memAddr
);
  default clocking mcb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_ce_low_len: assert property ($fell(memCe_b) |-> !memCe_b [*2] ##1 memCe_b)
    else $error("select low time wrong.");
  a_prech_min: assert property ($rose(memCe_b) |-> memCe_b [*2])
    else $error("precharge too short.");
  a_start_lag: assert property (reqValid && reqReady |-> ##2 $fell(memCe_b))
    else $error("select late.");
  a_rsp_time: assert property (reqValid && reqReady |-> ##4 rspValid ##1 !rspValid)
    else $error("completion misplaced.");
  a_addr_hold: assert property (!memCe_b |-> $stable(memAddr))
    else $error("address moved.");
  a_addr_load: assert property (reqValid && reqReady |=> memAddr == $past(reqAddr))
    else $error("address not loaded.");
  a_decode_map: assert property (reqValid && reqReady |=>
    {blockSel, colSel, rowSel} == $past(reqAddr)) else $error("decode wrong.");
  a_ready_back: assert property ($rose(memCe_b) |-> ##2 reqReady)
    else $error("not ready after precharge.");
endmodule : bnv_monitor

bind bnv_host bnv_monitor u_mon (.core_clk, .rst_b, .reqValid, .reqReady, .reqAddr,
  .rspValid, .blockSel, .rowSel, .colSel, .memCe_b, .memAddr);

// ===== bnv_mem_model.sv
// Behavioural model of the bytewide nonvolatile memory.
`timescale 1ns/1ns
module bnv_mem_model (
  input  wire logic        memCe_b,
  input  wire logic        memOe_b,
  input  wire logic        memWe_b,
  input  wire logic [14:0] memAddr,
  input  wire logic [7:0]  memDqOut,
  input  wire logic        memDqOe,
  output logic      [7:0]  memDqIn
);
  logic [7:0]  cells [32768];
  int          rowWear [8192];
  logic [14:0] held = 15'h0000;
  logic        isWrite = 1'h0;
  logic        valid = 1'h0;
  always @(negedge memCe_b)
  begin
    held = memAddr;
    isWrite = !memWe_b;
    valid = 1'h0;
    #70 valid = !memCe_b;
  end
  always @(posedge memCe_b)
  begin
    valid = 1'h0;
    rowWear[{held[14:10], held[7:0]}]++;
    if (isWrite)
      cells[held] = memDqOut;
  end
  assign memDqIn = (!memCe_b && !memOe_b && !isWrite && valid) ? cells[held] :
                   memDqOe ? memDqOut : ~cells[held];
endmodule : bnv_mem_model

// ===== test_bytewide_nv_memory_cycle_logic.sv
// Self-checking bench for the memory host controller.
`timescale 1ns/1ns
module test_bytewide_nv_memory_cycle_logic;
  logic        core_clk, rst_b, reqValid, reqWrite, reqReady, rspValid, rowRepeat, havePrev;
  logic        memCe_b, memOe_b, memWe_b, memDqOe;
  logic [14:0] reqAddr, memAddr, prevAddr;
  logic [7:0]  reqWdata, rspRdata, rowSel, memDqOut, memDqIn;
  logic [4:0]  blockSel;
  logic [1:0]  colSel;
  int          n_mismatch, compares;
  logic [9:0]  opW = 10'h11d;
  logic [14:0] opA [10] = '{15'h0000, 15'h0000, 15'h7fff, 15'h03ff, 15'h0400,
                            15'h7fff, 15'h03ff, 15'h0400, 15'h0100, 15'h0000};
  logic [7:0]  opD [10] = '{8'h5a, 8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'ha5, 8'h3c, 8'hc3, 8'h77, 8'h5a};

  bnv_host u_bnv_host (.core_clk, .rst_b, .reqValid, .reqWrite, .reqAddr, .reqWdata,
    .reqReady, .rspValid, .rspRdata, .blockSel, .rowSel, .colSel, .rowRepeat, .memCe_b,
    .memOe_b, .memWe_b, .memAddr, .memDqOut, .memDqOe, .memDqIn);
  bnv_mem_model u_bnv_mem_model (.memCe_b, .memOe_b, .memWe_b, .memAddr, .memDqOut,
    .memDqOe, .memDqIn);

  initial
  begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic do_op(input logic w, input logic [14:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'h1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    check(15'(reqReady), 15'h0001);
    reqValid = 1'h1;
    reqWrite = w;
    reqAddr = a;
    reqWdata = d;
    @(negedge core_clk);
    reqValid = 1'h0;
    reqAddr = ~a;
    check(15'(blockSel), 15'(a[14:10]));
    check(15'({colSel, rowSel}), 15'(a[9:0]));
    if (havePrev)
      check(15'(rowRepeat), 15'({a[14:10], a[7:0]} == {prevAddr[14:10], prevAddr[7:0]}));
    prevAddr = a;
    havePrev = 1'h1;
    n = 0;
    while (rspValid !== 1'h1 && n < 10)
    begin
      @(negedge core_clk);
      n++;
    end
    check(15'(n), 15'h0003);
    if (!w)
      check(15'(rspRdata), 15'(d));
  endtask : do_op

  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    n_mismatch = 0;
    compares = 0;
    havePrev = 1'h0;
    prevAddr = 15'h0000;
    rst_b = 1'h0;
    reqValid = 1'h0;
    reqWrite = 1'h0;
    reqAddr = 15'h0000;
    reqWdata = 8'h00;
    repeat (3) @(negedge core_clk);
    check(15'({memCe_b, memOe_b, memWe_b, memDqOe, reqReady, rspValid}), 15'h0038);
    rst_b = 1'h1;
    $display("test reset done");
    for (int i = 0; i < 10; i++)
    begin
      do_op(opW[i], opA[i], opD[i]);
      $display("test row %0d done", i);
    end
    repeat (2) @(negedge core_clk);
    reqValid = 1'h1;
    reqWrite = 1'h1;
    reqAddr = 15'h0200;
    reqWdata = 8'h99;
    @(negedge core_clk);
    reqValid = 1'h0;
    @(negedge core_clk);
    rst_b = 1'h0;
    #1;
    check(15'({memCe_b, memWe_b, memDqOe}), 15'h0006);
    havePrev = 1'h0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'h1;
    do_op(1'h0, 15'h7fff, 8'ha5);
    $display("test mid-cycle reset done");
    tally_and_finish;
  end

  // Whole run needs under a hundred cycles; this bound of 2500 cycles is far beyond it.
  initial
  begin
    #100000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule : test_bytewide_nv_memory_cycle_logic
